// File: pkg/sdd_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the drop detector
// Assumes: 8-bit register port, 4-bit word addresses
// Notes:   definitions only
`ifndef SDD_CONSTS_SVH
`define SDD_CONSTS_SVH

`define SDD_AW          4
`define SDD_DW          8
`define SDD_A_CTRL      4'h0
`define SDD_A_STAT      4'h1
`define SDD_A_CLR       4'h2
`define SDD_A_IEN       4'h3
`define SDD_A_SET       4'h4
`define SDD_A_CORE      4'h5

`define SDD_LVL_LSB     0
`define SDD_LVL_MSB     2
`define SDD_EN_BIT      4
`define SDD_RS_BIT      5
`define SDD_FLAG_BIT    0
`define SDD_GIE_BIT     0
`define SDD_PERIPHERAL_IRQ_ENABLE_BIT    1
`define SDD_LVL_RST     3'h4

`define SDD_CLK_NS      5
`define SDD_STAB_NS     10000
`define SDD_STAB_CYC    ((`SDD_STAB_NS + `SDD_CLK_NS - 1) / `SDD_CLK_NS)
`define SDD_CNT_W       12

`endif

// File: pkg/sdd_pkg.sv
// Purpose: types of the supply drop detector control
// Assumes: constants come from sdd_consts.svh
// Notes:   whole state of the top is one packed struct
`include "sdd_consts.svh"
package sdd_pkg;

    typedef enum logic [1:0] {
        SDD_RUN,
        SDD_SLEEP,
        SDD_WOKE
    } sdd_pwr_t;

    typedef struct packed {
        logic                 en;
        logic [2:0]           lvl;
        logic [`SDD_CNT_W-1:0] stab_cnt;
        logic                 stab_done;
        logic                 cmp_s1;
        logic                 cmp_s2;
        logic                 cmp_prev;
        logic                 osc_s1;
        logic                 osc_s2;
        logic                 flag;
        logic                 ie;
        logic                 global_irq_enable;
        logic                 peripheral_irq_enable;
        sdd_pwr_t             pwr;
        logic                 irq;
        logic                 wake;
        logic [`SDD_DW-1:0]   rdata;
    } sdd_state_t;

endpackage

// File: hw/sdd_top.sv
// Purpose: control, flag and interrupt logic of a programmable supply drop detector
// Assumes: cmp_above and osc_running are asynchronous; sleep and retire come from the core
// Notes:   reads return data in the cycle after the read strobe
// Operation
// - The low-supply flag stays set until software clears it.
// - Control bits 2-0 pick one of eight trip levels and reset to code 100.
// - Of the two crossings of the comparison, only a falling one sets the flag.
// - An interrupt is raised while flag, detector, peripheral and global enables are all set and the core is in run state.
// - A software write that sets the flag acts like a real detection.
// - Control bit 5 reads 1 once the reference is stable and only while the fast oscillator runs.
// - Detection results are ignored until the reference has had its settling time.
// - In sleep, a set flag with detector and peripheral enables wakes the device.
// - With global enable set, the interrupt is taken after the first instruction after wake.
`timescale 1ns/10ps
`default_nettype none
`include "sdd_consts.svh"

module sdd_top #(
    parameter int STAB_CYC = `SDD_STAB_CYC
) (
    input  wire logic               ref_clk,     // Core clock, 200 MHz
    input  wire logic               resetn,      // Sync reset, active low
    input  wire logic [`SDD_AW-1:0] addr,        // Register word address
    input  wire logic [`SDD_DW-1:0] wdata,       // Write data
    input  wire logic               wr,          // Write strobe
    input  wire logic               rd,          // Read strobe
    output logic      [`SDD_DW-1:0] rdata,       // Read data, cycle after rd
    input  wire logic               cmp_above,   // Supply above trip, async
    input  wire logic               osc_running, // Fast oscillator runs, async
    input  wire logic               sleep_in,    // Core is in sleep
    input  wire logic               instr_done,  // Core retired an instruction
    output logic                    det_power,   // Powers detector and reference
    output logic      [2:0]         trip_level,  // Selected trip level
    output logic                    irq,         // Interrupt request, level
    output logic                    wake         // Wake pulse
);
    import sdd_pkg::*;

    if (STAB_CYC < 1 || STAB_CYC >= (1 << `SDD_CNT_W)) begin : g_bad_stab
        $error("STAB_CYC out of range");
    end

    localparam logic [`SDD_CNT_W-1:0] STAB_LAST = `SDD_CNT_W'(STAB_CYC - 1);

    sdd_state_t s_r;
    sdd_state_t s_nxt;

    logic fall_seen;
    logic ref_ok;
    logic flag_set;
    logic flag_clr;
    logic wake_cond;
    logic [`SDD_DW-1:0] ctrl_view;

    always_comb begin
        s_nxt = s_r;
        // Only the second stage is read beyond the chain
        s_nxt.cmp_s1   = cmp_above;
        s_nxt.cmp_s2   = s_r.cmp_s1;
        s_nxt.osc_s1   = osc_running;
        s_nxt.osc_s2   = s_r.osc_s1;
        s_nxt.cmp_prev = s_r.cmp_s2;

        // Settling timer restarts on every enable
        if (!s_r.en) begin
            s_nxt.stab_cnt  = '0;
            s_nxt.stab_done = 1'b0;
        end else if (!s_r.stab_done) begin
            if (s_r.stab_cnt == STAB_LAST) begin
                s_nxt.stab_done = 1'b1;
            end else begin
                s_nxt.stab_cnt = s_r.stab_cnt + 1'b1;
            end
        end

        ref_ok    = s_r.en && s_r.stab_done;
        fall_seen = s_r.cmp_prev && !s_r.cmp_s2;
        ctrl_view = '0;
        ctrl_view[`SDD_LVL_MSB:`SDD_LVL_LSB] = s_r.lvl;
        ctrl_view[`SDD_EN_BIT] = s_r.en;
        ctrl_view[`SDD_RS_BIT] = ref_ok && s_r.osc_s2;

        flag_set = (fall_seen && ref_ok)
                 || (wr && addr == `SDD_A_SET && wdata[`SDD_FLAG_BIT]);
        flag_clr = wr && addr == `SDD_A_CLR && wdata[`SDD_FLAG_BIT];

        if (wr) begin
            unique case (addr)
                `SDD_A_CTRL: begin
                    s_nxt.lvl = wdata[`SDD_LVL_MSB:`SDD_LVL_LSB];
                    s_nxt.en  = wdata[`SDD_EN_BIT];
                end
                `SDD_A_IEN:  s_nxt.ie = wdata[`SDD_FLAG_BIT];
                `SDD_A_CORE: begin
                    s_nxt.global_irq_enable  = wdata[`SDD_GIE_BIT];
                    s_nxt.peripheral_irq_enable = wdata[`SDD_PERIPHERAL_IRQ_ENABLE_BIT];
                end
                default: ;
            endcase
        end

        // Set wins a tie with clear; nothing else clears the flag
        if (flag_set) begin
            s_nxt.flag = 1'b1;
        end else if (flag_clr) begin
            s_nxt.flag = 1'b0;
        end

        wake_cond  = s_r.flag && s_r.ie && s_r.peripheral_irq_enable;
        s_nxt.wake = 1'b0;
        unique case (s_r.pwr)
            SDD_RUN:   if (sleep_in) s_nxt.pwr = SDD_SLEEP;
            SDD_SLEEP: if (wake_cond) begin
                s_nxt.pwr  = SDD_WOKE;
                s_nxt.wake = 1'b1;
            end
            SDD_WOKE:  if (instr_done) s_nxt.pwr = SDD_RUN;
        endcase

        // Held off in sleep and until the first instruction after wake retires
        s_nxt.irq = s_r.flag && s_r.ie && s_r.peripheral_irq_enable && s_r.global_irq_enable
                    && s_r.pwr == SDD_RUN;

        s_nxt.rdata = '0;
        if (rd) begin
            unique case (addr)
                `SDD_A_CTRL: s_nxt.rdata = ctrl_view;
                `SDD_A_STAT: s_nxt.rdata[`SDD_FLAG_BIT] = s_r.flag;
                `SDD_A_IEN:  s_nxt.rdata[`SDD_FLAG_BIT] = s_r.ie;
                `SDD_A_CORE: begin
                    s_nxt.rdata[`SDD_GIE_BIT]  = s_r.global_irq_enable;
                    s_nxt.rdata[`SDD_PERIPHERAL_IRQ_ENABLE_BIT] = s_r.peripheral_irq_enable;
                end
                default: s_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_r          <= '0;
            s_r.lvl      <= `SDD_LVL_RST;
            s_r.cmp_s1   <= 1'b1;
            s_r.cmp_s2   <= 1'b1;
            s_r.cmp_prev <= 1'b1;
            s_r.pwr      <= SDD_RUN;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata      = s_r.rdata;
    assign det_power  = s_r.en;
    assign trip_level = s_r.lvl;
    assign irq        = s_r.irq;
    assign wake       = s_r.wake;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_flag_sticky: assert property (
        s_r.flag && !flag_clr |=> s_r.flag)
        else $error("flag dropped without a clear");

    chk_fall_sets: assert property (
        s_r.cmp_prev && !s_r.cmp_s2 && ref_ok |=> s_r.flag)
        else $error("falling crossing did not set flag");

    chk_rise_quiet: assert property (
        !s_r.flag && !(s_r.cmp_prev && !s_r.cmp_s2) && !(wr && addr == `SDD_A_SET)
        |=> !s_r.flag)
        else $error("flag set without cause");

    chk_irq_gate: assert property (
        s_r.flag && s_r.ie && s_r.peripheral_irq_enable && s_r.global_irq_enable && s_r.pwr == SDD_RUN |=> irq)
        else $error("irq missing with all enables");

    chk_irq_cause: assert property (
        irq |-> $past(s_r.flag) && $past(s_r.global_irq_enable) && $past(s_r.ie) && $past(s_r.peripheral_irq_enable))
        else $error("irq without flag and enables");

    chk_soft_set: assert property (
        wr && addr == `SDD_A_SET && wdata[`SDD_FLAG_BIT] |=> s_r.flag)
        else $error("software set ignored");

    chk_lvl_write: assert property (
        wr && addr == `SDD_A_CTRL |=> trip_level == $past(wdata[2:0]))
        else $error("trip level not written");

    chk_stab_wait: assert property (
        $rose(s_r.en) |-> !ctrl_view[`SDD_RS_BIT] [*8])
        else $error("reference stable too early");

    chk_wake_pulse: assert property (
        s_r.pwr == SDD_SLEEP && wake_cond |=> wake ##1 !wake)
        else $error("wake not a single pulse");

    chk_woke_hold: assert property (
        s_r.pwr == SDD_WOKE && !instr_done |=> !irq)
        else $error("irq before first instruction retired");

    chk_unimpl_zero: assert property (
        rd && addr == `SDD_A_CTRL |=> rdata[7:6] == 2'h0 && rdata[3] == 1'b0)
        else $error("unimplemented bits not zero");

    chk_irq_flag: assert property (
        !s_r.flag |=> !irq)
        else $error("irq without flag");

    chk_irq_ie: assert property (
        !s_r.ie |=> !irq)
        else $error("irq without detector enable");

    chk_irq_gie: assert property (
        !s_r.global_irq_enable |=> !irq)
        else $error("irq without global enable");

    chk_irq_peripheral_irq_enable: assert property (
        !s_r.peripheral_irq_enable |=> !irq)
        else $error("irq without peripheral enable");

    chk_sleep_mask: assert property (
        s_r.pwr != SDD_RUN |=> !irq)
        else $error("irq outside run state");

    chk_soft_clear: assert property (
        wr && addr == `SDD_A_CLR && wdata[`SDD_FLAG_BIT] && !flag_set |=> !s_r.flag)
        else $error("clear write ignored");

    chk_set_tie: assert property (
        flag_set && flag_clr |=> s_r.flag)
        else $error("clear won over a set");

    chk_en_write: assert property (
        wr && addr == `SDD_A_CTRL |=> det_power == $past(wdata[4]))
        else $error("enable not written");

    chk_en_keep: assert property (
        !(wr && addr == `SDD_A_CTRL) |=> $stable(det_power))
        else $error("enable changed without write");

    chk_lvl_keep: assert property (
        !(wr && addr == `SDD_A_CTRL) |=> $stable(trip_level))
        else $error("trip level changed without write");

    chk_stab_clear: assert property (
        !s_r.en |=> !s_r.stab_done)
        else $error("settled while disabled");

    chk_stab_done: assert property (
        s_r.en && s_r.stab_cnt == STAB_LAST |=> s_r.stab_done)
        else $error("settle timer did not finish");

    chk_fall_early: assert property (
        fall_seen && !ref_ok && !s_r.flag && !(wr && addr == `SDD_A_SET) |=> !s_r.flag)
        else $error("flag set before reference settled");

    chk_ref_osc: assert property (
        rd && addr == `SDD_A_CTRL && !s_r.osc_s2 |=> !rdata[`SDD_RS_BIT])
        else $error("stable bit set without oscillator");

    chk_ref_unset: assert property (
        rd && addr == `SDD_A_CTRL && !s_r.stab_done |=> !rdata[`SDD_RS_BIT])
        else $error("stable bit set before settling");

    chk_fall_once: assert property (
        fall_seen |=> !fall_seen)
        else $error("one crossing seen twice");

    chk_wake_cause: assert property (
        wake |-> $past(s_r.pwr) == SDD_SLEEP && $past(wake_cond))
        else $error("wake without cause");

    chk_woke_exit: assert property (
        s_r.pwr == SDD_WOKE && instr_done |=> s_r.pwr == SDD_RUN)
        else $error("no return to run after first instruction");

    chk_sleep_enter: assert property (
        s_r.pwr == SDD_RUN && sleep_in |=> s_r.pwr == SDD_SLEEP)
        else $error("sleep not entered");

    chk_sleep_stay: assert property (
        s_r.pwr == SDD_SLEEP && !wake_cond |=> s_r.pwr == SDD_SLEEP && !wake)
        else $error("left sleep without cause");

    chk_wake_ie: assert property (
        !s_r.ie |=> !wake)
        else $error("wake without detector enable");

    chk_wake_peripheral_irq_enable: assert property (
        !s_r.peripheral_irq_enable |=> !wake)
        else $error("wake without peripheral enable");

    cov_fall_irq:  cover property (s_r.cmp_prev && !s_r.cmp_s2 && ref_ok ##[1:4] irq);
    cov_sleep_wake: cover property (s_r.pwr == SDD_SLEEP ##1 wake);
    cov_soft_irq:  cover property (wr && addr == `SDD_A_SET ##[1:3] irq);
    cov_tie:       cover property (flag_set && flag_clr);
    cov_woke_irq:  cover property (s_r.pwr == SDD_WOKE ##1 s_r.pwr == SDD_RUN ##1 irq);

endmodule
`default_nettype wire

// File: bench/test_supply_drop_detect_control.sv
// Purpose: register-level test of the supply drop detector control block
// Assumes: STAB_CYC shortened to 8 so the settle time stays short
// Notes:   inputs change by non-blocking assignment on the rising edge
`timescale 1ns/10ps
`default_nettype none
`include "sdd_consts.svh"

module test_supply_drop_detect_control;
    import sdd_pkg::*;
    localparam int STAB = 8;
    logic               ref_clk, resetn, wr, rd, cmp_above, osc_running, sleep_in, instr_done;
    logic [`SDD_AW-1:0] addr;
    logic [`SDD_DW-1:0] wdata, rdata;
    logic               det_power, irq, wake;
    logic [2:0]         trip_level;
    int                 n_errors, total_checks, nw;

    sdd_top #(.STAB_CYC(STAB)) dut (
        .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cmp_above(cmp_above), .osc_running(osc_running),
        .sleep_in(sleep_in), .instr_done(instr_done), .det_power(det_power),
        .trip_level(trip_level), .irq(irq), .wake(wake));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Gap of one edge between strobes keeps each driver assignment unique per step
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a; rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk(name, exp, rdata);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic stop_test;
        if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        stop_test;
    end

    initial begin
        resetn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00;
        cmp_above = 1'b1; osc_running = 1'b1; sleep_in = 1'b0; instr_done = 1'b0;
        n_errors = 0; total_checks = 0;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        wait_cyc(1);
        chk("trip_level", 8'h04, {5'h00, trip_level});
        chk("det_power", 8'h00, {7'h00, det_power});
        rd_chk("ctrl", `SDD_A_CTRL, 8'h04);
        rd_chk("stat", `SDD_A_STAT, 8'h00);
        rd_chk("ien", `SDD_A_IEN, 8'h00);
        rd_chk("core", `SDD_A_CORE, 8'h00);
        rd_chk("unmapped", 4'hF, 8'h00);
        // Falling crossing before the reference settles must be dropped
        wr_reg(`SDD_A_CTRL, 8'hFF);
        cmp_above <= 1'b0;
        rd_chk("ctrl", `SDD_A_CTRL, 8'h17);
        wait_cyc(4);
        rd_chk("stat", `SDD_A_STAT, 8'h00);
        chk("det_power", 8'h01, {7'h00, det_power});
        @(posedge ref_clk) cmp_above <= 1'b1;
        for (int l = 0; l < 8; l++) begin
            wr_reg(`SDD_A_CTRL, 8'h10 | l[7:0]);
            wait_cyc(1);
            chk("trip_level", l[7:0], {5'h00, trip_level});
        end
        wait_cyc(STAB + 4);
        rd_chk("ctrl", `SDD_A_CTRL, 8'h37);
        @(posedge ref_clk) osc_running <= 1'b0;
        wait_cyc(4);
        rd_chk("ctrl", `SDD_A_CTRL, 8'h17);
        @(posedge ref_clk) osc_running <= 1'b1;
        wait_cyc(4);
        wr_reg(`SDD_A_CLR, 8'h01);
        @(posedge ref_clk) cmp_above <= 1'b0;
        wait_cyc(6);
        rd_chk("stat", `SDD_A_STAT, 8'h01);
        @(posedge ref_clk) cmp_above <= 1'b1;
        wait_cyc(20);
        rd_chk("stat", `SDD_A_STAT, 8'h01);
        @(posedge ref_clk) cmp_above <= 1'b0;
        wr_reg(`SDD_A_CLR, 8'h01);
        wait_cyc(8);
        rd_chk("stat", `SDD_A_STAT, 8'h01);
        rd_chk("clr", `SDD_A_CLR, 8'h00);
        wr_reg(`SDD_A_CLR, 8'h01);
        rd_chk("stat", `SDD_A_STAT, 8'h00);
        // Soft set, then every combination of the three enables
        wr_reg(`SDD_A_SET, 8'h01);
        rd_chk("stat", `SDD_A_STAT, 8'h01);
        for (int m = 0; m < 8; m++) begin
            wr_reg(`SDD_A_IEN, {7'h00, m[0]});
            wr_reg(`SDD_A_CORE, {6'h00, m[2:1]});
            wait_cyc(3);
            chk("irq", {7'h00, m == 7}, {7'h00, irq});
        end
        wr_reg(`SDD_A_CLR, 8'h01);
        wait_cyc(3);
        chk("irq", 8'h00, {7'h00, irq});
        // Sleep: wake once, interrupt held off until the first instruction retires
        @(posedge ref_clk) sleep_in <= 1'b1;
        wait_cyc(2);
        wr_reg(`SDD_A_SET, 8'h01);
        nw = 0;
        for (int i = 0; i < 10; i++) begin
            wait_cyc(1);
            if (wake === 1'b1) nw++;
            chk("irq", 8'h00, {7'h00, irq});
        end
        chk("wake_count", 8'h01, nw[7:0]);
        @(posedge ref_clk) sleep_in <= 1'b0;
        wait_cyc(3);
        chk("irq", 8'h00, {7'h00, irq});
        @(posedge ref_clk) instr_done <= 1'b1;
        @(posedge ref_clk) instr_done <= 1'b0;
        wait_cyc(3);
        chk("irq", 8'h01, {7'h00, irq});
        wr_reg(`SDD_A_CTRL, 8'h04);
        wait_cyc(1);
        chk("det_power", 8'h00, {7'h00, det_power});
        // Mid-run reset brings control, status and the outputs back
        wr_reg(`SDD_A_CTRL, 8'h13);
        @(posedge ref_clk) resetn <= 1'b0;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        wait_cyc(1);
        chk("trip_level", 8'h04, {5'h00, trip_level});
        chk("det_power", 8'h00, {7'h00, det_power});
        chk("irq", 8'h00, {7'h00, irq});
        rd_chk("stat", `SDD_A_STAT, 8'h00);
        rd_chk("ctrl", `SDD_A_CTRL, 8'h04);
        stop_test;
    end
endmodule
`default_nettype wire
